// [include/rvs_pkg.sv]
// package of constants and types for the regulator voltage supervisor
package rvs_pkg;
    localparam int RVS_NREG = 17;
    localparam int RVS_NCH = 3;
    localparam int RVS_NSLOT = 10;
    localparam int RVS_CLK_HZ = 20000000;
    localparam int RVS_SLOT_US = 100;
    localparam int RVS_SLOT_CYC = RVS_CLK_HZ / 1000000 * RVS_SLOT_US;
    localparam int RVS_RESET_HOLD_US = 1000;
    localparam int RVS_RESET_HOLD_CYC = RVS_CLK_HZ / 1000000 * RVS_RESET_HOLD_US;
    localparam int RVS_SEQ_FAST = 1;
    localparam int RVS_SEQ_ECO = 10;
    localparam logic [11:0] RVS_TEMP_OFFSET_ADDR = 12'h104;
    localparam logic [11:0] RVS_CTRL_ADDR = 12'h000;
    localparam logic [11:0] RVS_MONEN_ADDR = 12'h004;
    localparam logic [11:0] RVS_REGEN_ADDR = 12'h008;
    localparam logic [11:0] RVS_EVENT_ADDR = 12'h00C;
    localparam logic [11:0] RVS_RES_ADDR = 12'h010;
    localparam logic [11:0] RVS_IDX_ADDR = 12'h014;
    localparam logic [11:0] RVS_MAN_LOW_ADDR = 12'h018;
    localparam logic [11:0] RVS_MAN_HIGH_ADDR = 12'h01C;
    localparam logic [11:0] RVS_STATUS_ADDR = 12'h020;
    localparam logic [11:0] RVS_NOMINAL_ADDR = 12'h024;
    localparam int RVS_CTRL_MODE_LSB = 0;
    localparam int RVS_CTRL_ECO = 2;
    localparam int RVS_CTRL_DEB = 3;
    localparam int RVS_CTRL_ACTION = 4;
    localparam int RVS_CTRL_MASK = 5;
    localparam int RVS_CTRL_PGPIN = 6;
    localparam int RVS_CTRL_MANGO = 7;
    localparam int RVS_CTRL_MANCH_LSB = 8;
    localparam int RVS_CTRL_DELAY_LSB = 16;
    localparam logic [31:0] RVS_CTRL_RESET = 32'h0004_0000;
    localparam logic [7:0] RVS_TEMP_OFFSET_VAL = 8'h80;
    localparam logic [7:0] RVS_WINDOW_DIV = 8'h10;
    typedef enum logic [1:0] {
        RVS_MODE_OFF = 2'h0,
        RVS_MODE_SUPERVISE = 2'h1,
        RVS_MODE_MEASURE = 2'h2,
        RVS_MODE_BURST = 2'h3
    } rvs_mode_t;
    // group of each regulator: 0..5 group1, 6..11 group2, 12..16 group3
    function automatic logic [1:0] rvs_group(input logic [4:0] reg_id);
        if (reg_id < 5'h06)
            return 2'h0;
        else if (reg_id < 5'h0C)
            return 2'h1;
        return 2'h2;
    endfunction : rvs_group
endpackage : rvs_pkg

// [include/rvs_adc_if.sv]
// interface carrying conversion requests and results
`timescale 1ns/10ps
interface rvs_adc_if;
    logic start;
    logic [3:0] channel;
    logic done;
    logic [9:0] result;
    modport ctrl (output start, output channel, input done, input result);
    modport conv (input start, input channel, output done, output result);
endinterface : rvs_adc_if

// [hw/rvs_conv.sv]
// conversion front end: captures the sampled analog code one cycle after a start
`timescale 1ns/10ps
module rvs_conv
    import rvs_pkg::*;
(
    input wire logic clock,
    input wire logic reset_n,
    input wire logic [9:0] adcCode,
    rvs_adc_if.conv adc
);
    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
        begin
            adc.done <= 1'b0;
            adc.result <= 10'h000;
        end
        else
        begin
            adc.done <= adc.start;
            if (adc.start)
                adc.result <= adcCode;
        end
    end
endmodule : rvs_conv

// [hw/rvs_window.sv]
// relative threshold window around the nominal target of a regulator
`timescale 1ns/10ps
module rvs_window
    import rvs_pkg::*;
(
    input wire logic [7:0] nominal,
    input wire logic [7:0] sample,
    output logic below,
    output logic above
);
    logic [8:0] margin;
    logic [8:0] low;
    logic [8:0] high;
    always_comb
    begin
        // window tracks nominal, so a voltage change moves it too
        margin = {1'b0, nominal} / {1'b0, RVS_WINDOW_DIV};
        low = {1'b0, nominal} - margin;
        high = {1'b0, nominal} + margin;
        below = {1'b0, sample} < low;
        above = {1'b0, sample} > high;
    end
endmodule : rvs_window

// [hw/rvs_supervisor.sv]
// regulator voltage supervisor with wishbone register access
// What this block does
// - active only when mode enables; fixed channel
// - measure each 1 ms, economy 10 ms
// - thresholds follow nominal target, compare both
// - out of range: store result, index, event
// - supervise mode disables faulting regulator
// - settle delay after enable or voltage change
// - debounce needs two consecutive same-threshold hits
// - fixed regulator-to-channel assignment
// - several regulators measured in turn
// - keep supervising; latest fault recorded
// - clearing event resets index fields
// - masked: action select picks disable or reset
// - reset out held 1 ms and while bad
// - disabled regulators never cause reset
// - power good false if any disabled selected
// - measure mode: event on each result
// - burst mode: event after channel 10 slot
// - measurement modes: no compare, no shutdown
// - measure modes pause while interrupt pending
// - manual result 10 bits, low and high
// - ten-slot repeating scheduler order
`timescale 1ns/10ps
module rvs_supervisor
    import rvs_pkg::*;
(
    input wire logic clock,
    input wire logic reset_n,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [11:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic [9:0] adcCode,
    output logic [16:0] regulatorOn,
    output logic system_reset_out_n,
    output logic interrupt_request_n,
    output logic power_good_pin
);
    typedef enum logic [2:0] {
        RVS_SLOT_IDLE = 3'b001,
        RVS_SLOT_CONV = 3'b010,
        RVS_SLOT_DONE = 3'b100
    } rvs_slot_t;

    rvs_adc_if adc ();
    logic [31:0] ctrl;
    logic [16:0] per_regulator_monitor_enable;
    logic [16:0] regEnable;
    logic [7:0] nominal [RVS_NREG];
    logic [7:0] groupResult [RVS_NCH];
    logic [4:0] groupIndex [RVS_NCH];
    logic regulator_fault_event;
    logic [9:0] manualResult;
    logic [15:0] settle [RVS_NREG];
    logic [1:0] lastHit [RVS_NREG];
    logic [16:0] outOfRange;
    logic [11:0] slotCount;
    logic [3:0] slot;
    logic [3:0] seqCount;
    logic [4:0] cursor [RVS_NCH];
    rvs_slot_t slotState;
    logic slotAuto;
    logic [1:0] slotGroup;
    logic [4:0] slotReg;
    logic [14:0] holdCount;
    logic below;
    logic above;
    logic wbHit;
    logic wbWrite;
    logic setEvent;
    logic clearEvent;
    rvs_mode_t mode;
    logic measuring;
    logic paused;
    logic slotEnd;
    logic [31:0] next_rdata;

    assign mode = rvs_mode_t'(ctrl[RVS_CTRL_MODE_LSB +: 2]);
    assign measuring = (mode == RVS_MODE_MEASURE) || (mode == RVS_MODE_BURST);
    assign paused = measuring && regulator_fault_event && !ctrl[RVS_CTRL_MASK];
    assign wbHit = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign wbWrite = wbHit && wb_we_i;
    assign slotEnd = slotCount == 12'(RVS_SLOT_CYC - 1);
    // write of a set bit clears; host writes back the read value
    assign clearEvent = wbWrite && wb_adr_i == RVS_EVENT_ADDR && wb_sel_i[0] && wb_dat_i[0];

    rvs_conv conv (
        .clock(clock),
        .reset_n(reset_n),
        .adcCode(adcCode),
        .adc(adc)
    );
    rvs_window window (
        .nominal(nominal[slotReg]),
        .sample(adc.result[9:2]),
        .below(below),
        .above(above)
    );

    // scheduler slot timing
    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
        begin
            slotCount <= 12'h000;
            slot <= 4'h0;
            seqCount <= 4'h0;
        end
        else
        begin
            slotCount <= slotEnd ? 12'h000 : slotCount + 12'h001;
            if (slotEnd)
            begin
                slot <= (slot == 4'(RVS_NSLOT - 1)) ? 4'h0 : slot + 4'h1;
                if (slot == 4'(RVS_NSLOT - 1))
                    seqCount <= (seqCount == 4'(ctrl[RVS_CTRL_ECO] ? RVS_SEQ_ECO - 1
                        : RVS_SEQ_FAST - 1)) ? 4'h0 : seqCount + 4'h1;
            end
        end
    end

    // slot 1, 4, 7 are groups 1..3; all other slots manual
    always_comb
    begin
        slotGroup = 2'h0;
        slotAuto = 1'b0;
        unique case (slot)
            4'h1: slotAuto = 1'b1;
            4'h4:
            begin
                slotAuto = 1'b1;
                slotGroup = 2'h1;
            end
            4'h7:
            begin
                slotAuto = 1'b1;
                slotGroup = 2'h2;
            end
            default: slotAuto = 1'b0;
        endcase
    end

    // conversion request per slot
    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
        begin
            slotState <= RVS_SLOT_IDLE;
            adc.start <= 1'b0;
            adc.channel <= 4'h0;
            slotReg <= 5'h00;
        end
        else
        begin
            adc.start <= 1'b0;
            unique case (slotState)
                RVS_SLOT_IDLE:
                    if (slotCount == 12'h000 && slotAuto && mode != RVS_MODE_OFF
                        && !paused && seqCount == 4'h0
                        && per_regulator_monitor_enable[cursor[slotGroup]])
                    begin
                        adc.start <= 1'b1;
                        adc.channel <= 4'h8 + {2'h0, slotGroup};
                        slotReg <= cursor[slotGroup];
                        slotState <= RVS_SLOT_CONV;
                    end
                    else if (slotCount == 12'h000 && !slotAuto && ctrl[RVS_CTRL_MANGO])
                    begin
                        adc.start <= 1'b1;
                        adc.channel <= ctrl[RVS_CTRL_MANCH_LSB +: 4];
                        slotReg <= 5'h1F;
                        slotState <= RVS_SLOT_CONV;
                    end
                RVS_SLOT_CONV: slotState <= RVS_SLOT_DONE;
                RVS_SLOT_DONE: slotState <= RVS_SLOT_IDLE;
            endcase
        end
    end

    // k-th regulator after cur, wrapping inside its own group
    function automatic logic [4:0] grp_next(input logic [1:0] g, input logic [4:0] cur,
        input int k);
        int base;
        int size;
        base = int'(g) * 6;
        size = (g == 2'h2) ? RVS_NREG - 12 : 6;
        return 5'(base + (int'(cur) - base + k) % size);
    endfunction : grp_next

    // round robin over enabled regulators; each extra one adds a base period
    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
        begin
            for (int g = 0; g < RVS_NCH; g++)
                cursor[g] <= 5'(g * 6);
        end
        else if (slotEnd && slotAuto && seqCount == 4'h0)
        begin
            // scan far to near so the nearest enabled one wins
            for (int k = 6; k >= 1; k--)
            begin
                if (per_regulator_monitor_enable[grp_next(slotGroup, cursor[slotGroup], k)])
                    cursor[slotGroup] <= grp_next(slotGroup, cursor[slotGroup], k);
            end
        end
    end

    // settle delay after switch-on or target change
    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
        begin
            for (int r = 0; r < RVS_NREG; r++)
                settle[r] <= 16'h0000;
        end
        else
        begin
            for (int r = 0; r < RVS_NREG; r++)
            begin
                if (wbWrite && wb_adr_i == RVS_NOMINAL_ADDR && wb_dat_i[12:8] == 5'(r))
                    settle[r] <= ctrl[RVS_CTRL_DELAY_LSB +: 16];
                else if (wbWrite && wb_adr_i == RVS_REGEN_ADDR && wb_dat_i[r] && !regEnable[r])
                    settle[r] <= ctrl[RVS_CTRL_DELAY_LSB +: 16];
                else if (settle[r] != 16'h0000 && slotEnd)
                    settle[r] <= settle[r] - 16'h0001;
            end
        end
    end

    // evaluation of finished conversions
    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
        begin
            for (int g = 0; g < RVS_NCH; g++)
            begin
                groupResult[g] <= 8'h00;
                groupIndex[g] <= 5'h00;
            end
            for (int r = 0; r < RVS_NREG; r++)
                lastHit[r] <= 2'h0;
            outOfRange <= 17'h00000;
            manualResult <= 10'h000;
            setEvent <= 1'b0;
        end
        else
        begin
            setEvent <= 1'b0;
            if (clearEvent)
            begin
                for (int g = 0; g < RVS_NCH; g++)
                    groupIndex[g] <= 5'h00;
            end
            if (adc.done && slotReg == 5'h1F)
                manualResult <= adc.result;
            else if (adc.done && measuring)
            begin
                groupResult[slotGroup] <= adc.result[9:2];
                groupIndex[slotGroup] <= slotReg;
                setEvent <= mode == RVS_MODE_MEASURE;
            end
            else if (adc.done && mode == RVS_MODE_SUPERVISE && settle[slotReg] == 16'h0000
                && regEnable[slotReg])
            begin
                lastHit[slotReg] <= {above, below};
                outOfRange[slotReg] <= below || above;
                if ((below || above) && (!ctrl[RVS_CTRL_DEB]
                    || lastHit[slotReg] == {above, below}))
                begin
                    groupResult[slotGroup] <= adc.result[9:2];
                    groupIndex[slotGroup] <= slotReg;
                    setEvent <= 1'b1;
                end
            end
            if (slotEnd && slot == 4'h7 && mode == RVS_MODE_BURST && !paused)
                setEvent <= 1'b1;
        end
    end

    // event flag: a set in the clear cycle wins
    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
            regulator_fault_event <= 1'b0;
        else if (setEvent)
            regulator_fault_event <= 1'b1;
        else if (clearEvent)
            regulator_fault_event <= 1'b0;
    end

    // rail control: supervision shuts rails, reset action holds reset
    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
            regEnable <= 17'h00000;
        else if (wbWrite && wb_adr_i == RVS_REGEN_ADDR)
            regEnable <= wb_dat_i[16:0];
        else if (setEvent && mode == RVS_MODE_SUPERVISE
            && (!ctrl[RVS_CTRL_MASK] || !ctrl[RVS_CTRL_ACTION]))
            regEnable[slotReg] <= 1'b0;
    end

    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
            holdCount <= 15'h0000;
        else if (setEvent && mode == RVS_MODE_SUPERVISE && ctrl[RVS_CTRL_MASK]
            && ctrl[RVS_CTRL_ACTION] && regEnable[slotReg])
            holdCount <= 15'(RVS_RESET_HOLD_CYC);
        else if (holdCount != 15'h0000)
            holdCount <= holdCount - 15'h0001;
    end

    // outputs from flops
    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
        begin
            system_reset_out_n <= 1'b1;
            interrupt_request_n <= 1'b1;
            power_good_pin <= 1'b0;
            regulatorOn <= 17'h00000;
        end
        else
        begin
            // still bad keeps reset low even after the minimum hold
            system_reset_out_n <= !(holdCount != 15'h0000 || (ctrl[RVS_CTRL_ACTION]
                && ctrl[RVS_CTRL_MASK] && |(outOfRange & regEnable)));
            interrupt_request_n <= !(regulator_fault_event && !ctrl[RVS_CTRL_MASK]);
            power_good_pin <= ctrl[RVS_CTRL_MASK] && ctrl[RVS_CTRL_PGPIN]
                && !(|(per_regulator_monitor_enable & ~regEnable))
                && !(|(outOfRange & per_regulator_monitor_enable));
            regulatorOn <= regEnable;
        end
    end

    // register writes
    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
        begin
            ctrl <= RVS_CTRL_RESET;
            per_regulator_monitor_enable <= 17'h00000;
            for (int r = 0; r < RVS_NREG; r++)
                nominal[r] <= 8'h80;
        end
        else
        begin
            if (wbWrite && wb_adr_i == RVS_CTRL_ADDR)
                ctrl <= wb_dat_i;
            else if (adc.done && slotReg == 5'h1F)
                ctrl[RVS_CTRL_MANGO] <= 1'b0;
            if (wbWrite && wb_adr_i == RVS_MONEN_ADDR)
                per_regulator_monitor_enable <= wb_dat_i[16:0];
            if (wbWrite && wb_adr_i == RVS_NOMINAL_ADDR)
                nominal[wb_dat_i[12:8]] <= wb_dat_i[7:0];
        end
    end

    always_comb
    begin
        next_rdata = 32'h0000_0000;
        unique case (wb_adr_i)
            RVS_CTRL_ADDR: next_rdata = ctrl;
            RVS_MONEN_ADDR: next_rdata = {15'h0000, per_regulator_monitor_enable};
            RVS_REGEN_ADDR: next_rdata = {15'h0000, regEnable};
            RVS_EVENT_ADDR: next_rdata = {31'h0, regulator_fault_event};
            RVS_RES_ADDR: next_rdata = {8'h00, groupResult[2], groupResult[1], groupResult[0]};
            RVS_IDX_ADDR: next_rdata = {17'h0, groupIndex[2], groupIndex[1], groupIndex[0]};
            RVS_MAN_LOW_ADDR: next_rdata = {30'h0, manualResult[1:0]};
            RVS_MAN_HIGH_ADDR: next_rdata = {24'h0, manualResult[9:2]};
            RVS_STATUS_ADDR: next_rdata = {15'h0, outOfRange};
            RVS_TEMP_OFFSET_ADDR: next_rdata = {24'h0, RVS_TEMP_OFFSET_VAL};
            default: next_rdata = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
        begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end
        else
        begin
            wb_ack_o <= wbHit;
            wb_dat_o <= next_rdata;
        end
    end

    pulse_event_a: assert property (@(posedge clock) disable iff (!reset_n)
        setEvent |=> regulator_fault_event) else $error("event not set");
    clear_index_a: assert property (@(posedge clock) disable iff (!reset_n)
        clearEvent && !setEvent && !adc.done |=> groupIndex[0] == 5'h00)
        else $error("index not cleared");
    reset_hold_a: assert property (@(posedge clock) disable iff (!reset_n)
        holdCount == 15'(RVS_RESET_HOLD_CYC) |=> !system_reset_out_n)
        else $error("reset not asserted");
    slot_wrap_a: assert property (@(posedge clock) disable iff (!reset_n)
        slotEnd && slot == 4'h9 |=> slot == 4'h0) else $error("slot wrap wrong");
    measure_noshut_a: assert property (@(posedge clock) disable iff (!reset_n)
        measuring && !(wbWrite && wb_adr_i == RVS_REGEN_ADDR) |=> $stable(regEnable)
        || !$past(measuring)) else $error("rail changed in measurement");
    pause_hold_a: assert property (@(posedge clock) disable iff (!reset_n)
        paused && slotState == RVS_SLOT_IDLE && slotAuto |=> !adc.start)
        else $error("measured while paused");
    no_reset_off_a: assert property (@(posedge clock) disable iff (!reset_n)
        !ctrl[RVS_CTRL_ACTION] && holdCount == 15'h0000 |=> system_reset_out_n)
        else $error("reset without action");
    pg_disabled_a: assert property (@(posedge clock) disable iff (!reset_n)
        |(per_regulator_monitor_enable & ~regEnable) |=> !power_good_pin)
        else $error("power good with disabled rail");
endmodule : rvs_supervisor

// [verification/rvs_rail_model.sv]
// behavioural model of the supervised rails seen by the converter input
`timescale 1ns/10ps
module rvs_rail_model
(
    input wire logic [16:0] regulatorOn,
    input wire logic [9:0] railLevel,
    output logic [9:0] adcCode
);
    // a rail with every regulator off reads ground, never the last level
    assign adcCode = (|regulatorOn) ? railLevel : 10'h000;
endmodule : rvs_rail_model

// [verification/testbench.sv]
// self-checking bench for the regulator voltage supervisor
`timescale 1ns/10ps
module testbench
    import rvs_pkg::*;
();
    logic clock, reset_n, wbCyc, wbStb, wbWe, ack, rstOutN, irqN, powerGood;
    logic [11:0] wbAdr;
    logic [3:0] wbSel;
    logic [31:0] wbDat, datOut, rd, seed;
    logic [16:0] regOn;
    logic [9:0] adcCode, railLevel, code;
    int fail_count, compares, tries;

    rvs_supervisor DUT (.clock(clock), .reset_n(reset_n), .wb_cyc_i(wbCyc), .wb_stb_i(wbStb),
        .wb_we_i(wbWe), .wb_adr_i(wbAdr), .wb_sel_i(wbSel), .wb_dat_i(wbDat),
        .wb_dat_o(datOut), .wb_ack_o(ack), .adcCode(adcCode), .regulatorOn(regOn),
        .system_reset_out_n(rstOutN), .interrupt_request_n(irqN),
        .power_good_pin(powerGood));
    rvs_rail_model rails (.regulatorOn(regOn), .railLevel(railLevel), .adcCode(adcCode));

    initial
    begin
        clock = 1'b0;
        forever #25 clock = ~clock;
    end

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr

    // automatic results keep only the eight upper bits of the code
    function automatic logic [7:0] smp(input logic [9:0] c);
        return c[9:2];
    endfunction : smp

    task close_out;
        $display("compares %0d mismatches %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : close_out

    task check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task wb(input logic we, input logic [11:0] adr, input logic [31:0] dat);
        int n;
        n = 0;
        @(posedge clock);
        wbCyc <= 1'b1;
        wbStb <= 1'b1;
        wbWe <= we;
        wbAdr <= adr;
        wbDat <= dat;
        do
        begin
            @(posedge clock);
            n++;
        end while (ack !== 1'b1 && n < 20);
        rd = datOut;
        wbCyc <= 1'b0;
        wbStb <= 1'b0;
        if (ack !== 1'b1)
        begin
            fail_count++;
            $display("[ERR] %0t bus answer missing", $time);
            close_out;
        end
    endtask : wb

    // which 0 watches the interrupt line, 1 the reset output
    task wait_pin(input logic which, input logic lvl, input int lim);
        int n;
        n = 0;
        while ((which ? rstOutN : irqN) !== lvl && n < lim)
        begin
            @(posedge clock);
            n++;
        end
        if ((which ? rstOutN : irqN) !== lvl)
        begin
            fail_count++;
            $display("[ERR] %0t pin wait timed out", $time);
            close_out;
        end
    endtask : wait_pin

    task do_reset;
        @(posedge clock);
        reset_n <= 1'b0;
        repeat (16) @(posedge clock);
        reset_n <= 1'b1;
    endtask : do_reset

    initial
    begin
        reset_n = 1'b0;
        {wbCyc, wbStb, wbWe} = 3'h0;
        wbAdr = 12'h000;
        wbSel = 4'hF;
        wbDat = 32'h0000_0000;
        railLevel = 10'h200;
        seed = 32'he3ffcce9;
        fail_count = 0;
        compares = 0;
        do_reset;
        wb(1'b0, RVS_CTRL_ADDR, 32'h0);
        check(rd, RVS_CTRL_RESET);
        wb(1'b0, RVS_TEMP_OFFSET_ADDR, 32'h0);
        check(rd[7:0], RVS_TEMP_OFFSET_VAL);
        wb(1'b0, 12'h100, 32'h0);
        check(rd, 32'h0);
        check({rstOutN, irqN}, 2'h3);
        $display("test reset values done");

        // supervise: regulator 3 of group 1 drops below its window
        seed = lfsr(seed);
        code = {2'h0, seed[5:0], 2'h0};
        railLevel <= code;
        wb(1'b1, RVS_NOMINAL_ADDR, 32'h0000_0380);
        wb(1'b1, RVS_REGEN_ADDR, 32'h8);
        wb(1'b1, RVS_MONEN_ADDR, 32'h8);
        wb(1'b1, RVS_CTRL_ADDR, 32'h0);
        repeat (5000) @(posedge clock);
        check(irqN, 1'b1);
        wb(1'b1, RVS_CTRL_ADDR, 32'h1);
        wait_pin(1'b0, 1'b0, 30000);
        wb(1'b0, RVS_RES_ADDR, 32'h0);
        check(rd[7:0], smp(code));
        wb(1'b0, RVS_IDX_ADDR, 32'h0);
        check(rd[4:0], 5'h03);
        check(regOn[3], 1'b0);
        wb(1'b0, RVS_EVENT_ADDR, 32'h0);
        check(rd[0], 1'b1);
        wb(1'b1, RVS_EVENT_ADDR, rd);
        wb(1'b0, RVS_IDX_ADDR, 32'h0);
        check(rd[14:0], 15'h0);
        $display("test supervise done");

        // masked fault with reset action on regulator 6 of group 2
        do_reset;
        railLevel <= 10'h100;
        wb(1'b1, RVS_NOMINAL_ADDR, 32'h0000_0680);
        wb(1'b1, RVS_REGEN_ADDR, 32'h40);
        wb(1'b1, RVS_MONEN_ADDR, 32'h40);
        // power-good pin selected as well
        wb(1'b1, RVS_CTRL_ADDR, 32'h71);
        wait_pin(1'b1, 1'b0, 30000);
        railLevel <= 10'h200;
        repeat (19990) @(posedge clock);
        check(rstOutN, 1'b0);
        check(regOn[6], 1'b1);
        check(powerGood, 1'b0);
        wait_pin(1'b1, 1'b1, 45000);
        check(powerGood, 1'b1);
        $display("test reset action done");

        // measurement only on regulator 12 of group 3
        do_reset;
        seed = lfsr(seed);
        code = seed[9:0];
        railLevel <= code;
        wb(1'b1, RVS_NOMINAL_ADDR, 32'h0000_0C80);
        wb(1'b1, RVS_REGEN_ADDR, 32'h1000);
        wb(1'b1, RVS_MONEN_ADDR, 32'h1000);
        wb(1'b1, RVS_CTRL_ADDR, 32'h2);
        wait_pin(1'b0, 1'b0, 30000);
        wb(1'b0, RVS_RES_ADDR, 32'h0);
        check(rd[23:16], smp(code));
        check(regOn[12], 1'b1);
        railLevel <= ~code;
        repeat (20000) @(posedge clock);
        wb(1'b0, RVS_RES_ADDR, 32'h0);
        check(rd[23:16], smp(code));
        wb(1'b0, RVS_EVENT_ADDR, 32'h0);
        wb(1'b1, RVS_EVENT_ADDR, rd);
        repeat (3) @(posedge clock);
        check(irqN, 1'b1);
        // burst: event when the channel 10 slot ends
        wb(1'b1, RVS_CTRL_ADDR, 32'h3);
        wait_pin(1'b0, 1'b0, 5000);
        wb(1'b0, RVS_EVENT_ADDR, 32'h0);
        check(rd[0], 1'b1);
        $display("test measure done");

        // manual conversion with automatic supervision off
        do_reset;
        seed = lfsr(seed);
        code = seed[9:0];
        railLevel <= code;
        wb(1'b1, RVS_REGEN_ADDR, 32'h1);
        wb(1'b1, RVS_MONEN_ADDR, 32'h0);
        wb(1'b1, RVS_CTRL_ADDR, 32'h0000_0880);
        tries = 0;
        do
        begin
            repeat (500) @(posedge clock);
            wb(1'b0, RVS_CTRL_ADDR, 32'h0);
            tries++;
        end while (rd[RVS_CTRL_MANGO] !== 1'b0 && tries < 20);
        check(rd[RVS_CTRL_MANGO], 1'b0);
        if (rd[RVS_CTRL_MANGO] !== 1'b0)
            close_out;
        wb(1'b0, RVS_MAN_LOW_ADDR, 32'h0);
        check(rd[1:0], code[1:0]);
        wb(1'b0, RVS_MAN_HIGH_ADDR, 32'h0);
        check(rd[7:0], code[9:2]);
        $display("test manual done");
        close_out;
    end
endmodule : testbench
